// File: ecwp_params.svh
// Purpose: constants for the event counter / watchdog prescaler block
// Assumes: one clock, synchronous active-high reset
// Notes:   configuration bit positions and reset values
`ifndef ECWP_PARAMS_SVH
`define ECWP_PARAMS_SVH

// ****************************************
// configuration field positions
// ****************************************
`define ECWP_CFG_INT_EN_BIT    6
`define ECWP_CFG_SRC_BIT       5
`define ECWP_CFG_EDGE_BIT      4
`define ECWP_CFG_ASSIGN_BIT    3
`define ECWP_CFG_RATE_MSB      2
`define ECWP_CFG_RATE_LSB      0

// ****************************************
// reset values and counts
// ****************************************
`define ECWP_CFG_RESET         8'hff
`define ECWP_COUNT_RESET       8'h00
`define ECWP_COUNT_MAX         8'hff
`define ECWP_WDT_TICK_NS       1000
`define ECWP_CLK_NS            8
`define ECWP_WDT_TICK_CYCLES   (`ECWP_WDT_TICK_NS / `ECWP_CLK_NS)

`endif

// File: ecwp_pkg.sv
// Purpose: types for the event counter / watchdog prescaler block
// Assumes: nothing beyond the params header
// Notes:   holds types only
package ecwp_pkg;
   typedef logic [7:0] ecwp_byte_type;
   typedef enum logic [0:0] {
      ecwp_to_counter  = 1'b0,
      ecwp_to_watchdog = 1'b1
   } ecwp_assign_type;
endpackage

// File: ecwp_prescaler.sv
// Purpose: shared 8-bit divide-by-2^k prescaler
// Assumes: tick_in is a one-cycle pulse
// Notes:   count is internal only, no access path
`timescale 1ns/1ps
`include "ecwp_params.svh"

module ecwp_prescaler (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   // control
   input  wire logic                  clear,
   input  wire logic [3:0]            shift,
   // ticks
   input  wire logic                  tick_in,
   output logic                       tick_out
);
   ecwp_pkg::ecwp_byte_type count_ff;
   logic [8:0]              nxt_count;
   logic [8:0]              limit;

   always_comb begin
      nxt_count = {1'b0, count_ff} + 9'h001;
      limit     = 9'h001 << shift;
   end

   // ****************************************
   // divider
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst || clear) begin
         count_ff <= `ECWP_COUNT_RESET;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (shift == 4'h0) begin
            tick_out <= tick_in;
         end else if (tick_in) begin
            if (nxt_count == limit) begin
               count_ff <= `ECWP_COUNT_RESET;
               tick_out <= 1'b1;
            end else begin
               count_ff <= nxt_count[7:0];
            end
         end
      end
   end
endmodule // ecwp_prescaler

// File: ecwp_core.sv
// Purpose: 8-bit event counter and 8-bit watchdog sharing one prescaler
// Assumes: inputs synchronous to clk_sys; instr_tick is one pulse per
//          instruction cycle
// Notes:   config arrives as a port byte, no register bus
//
// Function
// - 8-bit event counter, extendable to 16 bits through the prescaler
// - 8-bit watchdog timer shares the one prescaler with the counter
// - source bit clear: counter advances once per instruction cycle
// - source bit set: counter advances on valid pin transitions
// - edge bit set selects falling edges, clear selects rising edges
// - increment wrap from ff to 00, outside load and return-with-offset, raises an interrupt request
// - no pending flag; software reads the count to see a wrap
// - assign bit set: watchdog overflow drives the prescaler
// - on the watchdog the prescaler divides the watchdog overflow
// - assign bit clear: prescaler output supplies counter increments
// - three-bit rate field sets the division for either user
// - prescaler count has no read or write access path
// - prescaler serves only one of counter or watchdog at a time
// - rollover interrupt gated by its own configuration enable bit
// - return-with-offset adds the working value to the counter
`timescale 1ns/1ps
`include "ecwp_params.svh"

module ecwp_core (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  sys_rst,
   // configuration byte
   input  wire logic [7:0]            config_byte,
   // instruction side
   input  wire logic                  instr_tick,
   input  wire logic                  counter_wr,
   input  wire logic [7:0]            counter_wr_data,
   input  wire logic                  interrupt_return_with_offset,
   input  wire logic [7:0]            work_value,
   input  wire logic                  watchdog_clear,
   input  wire logic                  watchdog_enable,
   // counter pin
   input  wire logic                  event_counter_pin,
   // status
   output logic [7:0]                 event_counter,
   output logic                       counter_irq,
   output logic                       watchdog_reset_req
);
   logic                    pin_q_ff;
   logic                    edge_event;
   logic                    wdt_base_ff;
   logic [15:0]             wdt_div_ff;
   ecwp_pkg::ecwp_byte_type watchdog_timer_ff;
   ecwp_pkg::ecwp_assign_type prescaler_assign;
   logic [2:0]              rate;
   logic                    raw_tick;
   logic                    pre_in;
   logic                    pre_out;
   logic                    pre_clear;
   logic [3:0]              shift;
   logic                    counter_inc;
   logic                    wdt_ovf;
   logic                    assign_q_ff;
   logic [7:0]              nxt_counter;

   assign prescaler_assign =
      ecwp_pkg::ecwp_assign_type'(config_byte[`ECWP_CFG_ASSIGN_BIT]);
   assign rate = config_byte[`ECWP_CFG_RATE_MSB:`ECWP_CFG_RATE_LSB];

   // ****************************************
   // external pin edge detect
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pin_q_ff <= 1'b0;
      end else begin
         pin_q_ff <= event_counter_pin;
      end
   end

   always_comb begin
      if (config_byte[`ECWP_CFG_EDGE_BIT]) begin
         edge_event = pin_q_ff & ~event_counter_pin;
      end else begin
         edge_event = ~pin_q_ff & event_counter_pin;
      end
   end

   // source select
   assign raw_tick = config_byte[`ECWP_CFG_SRC_BIT] ? edge_event
                                                    : instr_tick;

   // ****************************************
   // watchdog base tick divider
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !watchdog_enable || watchdog_clear) begin
         wdt_div_ff  <= 16'h0000;
         wdt_base_ff <= 1'b0;
      end else if (wdt_div_ff == 16'(`ECWP_WDT_TICK_CYCLES - 1)) begin
         wdt_div_ff  <= 16'h0000;
         wdt_base_ff <= 1'b1;
      end else begin
         wdt_div_ff  <= wdt_div_ff + 16'h0001;
         wdt_base_ff <= 1'b0;
      end
   end

   // ****************************************
   // watchdog 8-bit count
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !watchdog_enable || watchdog_clear) begin
         watchdog_timer_ff <= `ECWP_COUNT_RESET;
      end else if (wdt_base_ff) begin
         watchdog_timer_ff <= watchdog_timer_ff + 8'h01;
      end
   end

   assign wdt_ovf = wdt_base_ff && (watchdog_timer_ff == `ECWP_COUNT_MAX);

   // ****************************************
   // prescaler routing, one user only
   // ****************************************
   always_comb begin
      if (prescaler_assign == ecwp_pkg::ecwp_to_watchdog) begin
         pre_in = wdt_ovf;
         shift  = {1'b0, rate};
      end else begin
         pre_in = raw_tick;
         shift  = {1'b0, rate} + 4'h1;
      end
   end

   // reassignment restarts the count so no stale residue leaks over
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         assign_q_ff <= 1'b1;
      end else begin
         assign_q_ff <= config_byte[`ECWP_CFG_ASSIGN_BIT];
      end
   end
   assign pre_clear = assign_q_ff != config_byte[`ECWP_CFG_ASSIGN_BIT];

   // count held inside, no port exposes it
   ecwp_prescaler u_prescaler (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .clear    (pre_clear),
      .shift    (shift),
      .tick_in  (pre_in),
      .tick_out (pre_out)
   );

   assign counter_inc =
      (prescaler_assign == ecwp_pkg::ecwp_to_watchdog) ? raw_tick
                                                       : pre_out;

   // ****************************************
   // event counter
   // ****************************************
   always_comb begin
      nxt_counter = event_counter;
      if (counter_wr) begin
         nxt_counter = counter_wr_data;
      end else if (interrupt_return_with_offset) begin
         nxt_counter = event_counter + work_value
                       + {7'h00, counter_inc};
      end else if (counter_inc) begin
         nxt_counter = event_counter + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         event_counter <= `ECWP_COUNT_RESET;
      end else begin
         event_counter <= nxt_counter;
      end
   end

   // ****************************************
   // interrupt pulse, no sticky flag kept
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         counter_irq <= 1'b0;
      end else begin
         counter_irq <= !counter_wr && !interrupt_return_with_offset
                        && counter_inc
                        && (event_counter == `ECWP_COUNT_MAX)
                        && config_byte[`ECWP_CFG_INT_EN_BIT];
      end
   end

   // ****************************************
   // watchdog reset request
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         watchdog_reset_req <= 1'b0;
      end else if (prescaler_assign == ecwp_pkg::ecwp_to_watchdog) begin
         watchdog_reset_req <= pre_out;
      end else begin
         watchdog_reset_req <= wdt_ovf;
      end
   end
endmodule // ecwp_core

// File: ecwp_core_props.sv
// Purpose: port checks for ecwp_core
// Assumes: one clock domain, sync reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module ecwp_core_props (
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   // inputs
   input wire logic [7:0] config_byte,
   input wire logic       instr_tick,
   input wire logic       counter_wr,
   input wire logic [7:0] counter_wr_data,
   input wire logic       interrupt_return_with_offset,
   input wire logic [7:0] work_value,
   input wire logic       watchdog_clear,
   input wire logic       watchdog_enable,
   // outputs
   input wire logic [7:0] event_counter,
   input wire logic       counter_irq,
   input wire logic       watchdog_reset_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [15:0] wd_cnt_ff;
   logic        plain;
   // internal source, prescaler away, no load; offset not excluded
   assign plain = !config_byte[5] && config_byte[3] && !counter_wr;
   // only counts while enabled, so a paused watchdog never trips it
   always_ff @(posedge clk_sys) begin
      if (sys_rst || watchdog_clear || watchdog_reset_req) begin
         wd_cnt_ff <= 16'h0000;
      end else if (watchdog_enable && wd_cnt_ff != 16'hffff) begin
         wd_cnt_ff <= wd_cnt_ff + 16'h0001;
      end
   end
   a_tick_adds_one: assert property (
      plain && instr_tick && !interrupt_return_with_offset &&
      $stable(config_byte) |=> event_counter == $past(event_counter) + 8'h01)
      else $error("tick did not add one");
   a_idle_holds: assert property (
      plain && !instr_tick && !interrupt_return_with_offset &&
      $stable(config_byte) |=> $stable(event_counter))
      else $error("counter moved while idle");
   a_offset_adds: assert property (
      plain && !instr_tick && interrupt_return_with_offset &&
      $stable(config_byte) |=>
      event_counter == $past(event_counter) + $past(work_value))
      else $error("offset add wrong");
   a_irq_on_wrap: assert property (
      counter_irq |-> event_counter == 8'h00 && $past(event_counter) == 8'hff)
      else $error("irq without wrap");
   a_wrap_raises: assert property (
      plain && instr_tick && !interrupt_return_with_offset &&
      config_byte[6] && event_counter == 8'hff && $stable(config_byte)
      |=> counter_irq)
      else $error("wrap gave no irq");
   a_irq_enabled: assert property (
      counter_irq |-> $past(config_byte[6]))
      else $error("irq while masked");
   a_irq_single: assert property (
      counter_irq |=> !counter_irq)
      else $error("irq held");
   a_wdt_single: assert property (
      watchdog_reset_req |=> !watchdog_reset_req)
      else $error("reset request held");
   a_wdt_spacing: assert property (
      watchdog_reset_req |-> wd_cnt_ff >= 16'h7cfe)
      else $error("reset request too early");
endmodule // ecwp_core_props

// File: ecwp_pin_model.sv
// Purpose: external event source on the counter pin
// Assumes: pin is sampled on clk_sys
// Notes:   changes are three cycles apart so none is missed
`timescale 1ns/1ps
module ecwp_pin_model (
   // clock
   input wire logic clk_sys,
   // pin
   output logic     pin
);
   initial pin = 1'b0;
   task automatic toggle(int n);
      repeat (n) begin
         repeat (3) @(posedge clk_sys);
         #1 pin = !pin;
      end
   endtask
endmodule // ecwp_pin_model

// File: event_counter_watchdog_prescaler_tb.sv
// Purpose: self-checking bench for ecwp_core
// Assumes: inputs change 1 ns after the rising edge
// Notes:   the watchdog run takes most of the cycle budget
`timescale 1ns/1ps
`define CHECK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module event_counter_watchdog_prescaler_tb;
   logic       clk_sys = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] config_byte = 8'h08;
   logic       tick = 1'b0;
   logic       wr = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic       offset = 1'b0;
   logic [7:0] work = 8'h00;
   logic       wd_clear = 1'b0;
   logic       wd_en = 1'b0;
   logic       pin;
   logic [7:0] count;
   logic       irq;
   logic       req;
   int         num_errors = 0;
   int         checks = 0;
   int         cycles = 0;
   int         irqs = 0;
   int         reqs = 0;
   // config, ticks, pin toggles from current level, expected count
   int rows [7][4] = '{'{'h08,5,0,5}, '{'h00,8,0,4}, '{'h02,16,0,2},
      '{'h07,256,0,1}, '{'h28,0,3,2}, '{'h38,0,1,1}, '{'h20,0,8,2}};
   always #4 clk_sys = !clk_sys;
   ecwp_pin_model pm (.clk_sys(clk_sys), .pin(pin));
   ecwp_core uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .config_byte(config_byte), .instr_tick(tick), .counter_wr(wr),
      .counter_wr_data(wr_data), .interrupt_return_with_offset(offset),
      .work_value(work), .watchdog_clear(wd_clear),
      .watchdog_enable(wd_en), .event_counter_pin(pin),
      .event_counter(count), .counter_irq(irq), .watchdog_reset_req(req));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic step(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic load(logic [7:0] v);
      wr = 1'b1;
      wr_data = v;
      step(1);
      wr = 1'b0;
   endtask
   task automatic ticks(int n);
      tick = 1'b1;
      step(n);
      tick = 1'b0;
   endtask
   // pulse counts; ceiling is well past the 66000-cycle watchdog run
   always @(posedge clk_sys) begin
      cycles++;
      if (irq === 1'b1) irqs++;
      if (req === 1'b1) reqs++;
      if (cycles == 90000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      step(20);
      sys_rst = 1'b0;
      `CHECK({count, irq, req}, 10'h000)
      for (int i = 0; i < 7; i++) begin
         config_byte = rows[i][0][7:0];
         load(8'h00);
         ticks(rows[i][1]);
         pm.toggle(rows[i][2]);
         step(4);
         `CHECK(count, rows[i][3][7:0])
         $display("row %0d done", i);
      end
      config_byte = 8'h48;
      load(8'hff);
      ticks(1);
      `CHECK(count, 8'h00)
      `CHECK(irq, 1'b1)
      config_byte = 8'h08;
      load(8'hff);
      ticks(1);
      step(2);
      `CHECK(irqs, 1)
      $display("wrap done");
      config_byte = 8'h48;
      load(8'h10);
      offset = 1'b1;
      work = 8'h25;
      step(1);
      `CHECK(count, 8'h35)
      tick = 1'b1;
      step(1);
      tick = 1'b0;
      `CHECK(count, 8'h5b)
      work = 8'hb0;
      step(1);
      offset = 1'b0;
      step(2);
      `CHECK({count, irqs[7:0]}, 16'h0b01)
      sys_rst = 1'b1;
      step(2);
      sys_rst = 1'b0;
      `CHECK(count, 8'h00)
      $display("offset done");
      config_byte = 8'h09;
      wd_en = 1'b1;
      wd_clear = 1'b1;
      step(1);
      wd_clear = 1'b0;
      step(40000);
      `CHECK(reqs, 0)
      step(26000);
      `CHECK(reqs, 1)
      $display("watchdog done");
      complete_run();
   end
endmodule // event_counter_watchdog_prescaler_tb
bind ecwp_core ecwp_core_props u_props (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .config_byte(config_byte), .instr_tick(instr_tick),
   .counter_wr(counter_wr), .counter_wr_data(counter_wr_data),
   .interrupt_return_with_offset(interrupt_return_with_offset),
   .work_value(work_value), .watchdog_clear(watchdog_clear),
   .watchdog_enable(watchdog_enable), .event_counter(event_counter),
   .counter_irq(counter_irq), .watchdog_reset_req(watchdog_reset_req));
